// ===== hw/stdi_defines.vh
// Constants for the safety terminal diagnostic indicator block.
// Assumes inclusion by bare name from files under hw/.
`ifndef STDI_DEFINES_VH
`define STDI_DEFINES_VH
// Diagnostic fault codes
`define STDI_CODE_NONE 16'h0000
`define STDI_CODE_TEMP_HIGH 16'h0005
`define STDI_CODE_TEMP_LOW 16'h0006
`define STDI_CODE_TEMP_DIFF 16'h0007
`define STDI_CODE_OV_FIRST 16'h0101
`define STDI_CODE_OV_SECOND 16'h0102
`define STDI_CODE_UV_FIRST 16'h0103
`define STDI_CODE_UV_SECOND 16'h0104
// Protocol versions and checksum lengths in bytes
`define STDI_PROTO_V1 2'h1
`define STDI_PROTO_V2 2'h2
`define STDI_CRC_LEN_V1 2'h2
`define STDI_CRC_LEN_V2 2'h3
// Blink timing: tick period in us, clock in kHz
`define STDI_CLK_KHZ 10000
`define STDI_TICK_US 1000
`define STDI_TICK_CYCLES ((`STDI_CLK_KHZ * `STDI_TICK_US) / 1000)
// Timing in ticks (1 ms each)
`define STDI_PULSE_TICKS 200
`define STDI_GAP_TICKS 200
`define STDI_PAUSE_TICKS 1000
`endif

// ===== hw/stdi_tick_div.v
// Tick divider: one-cycle enable every DIV clock cycles.
// Assumes a single free-running clock and async active-low reset.
`default_nettype none
module stdi_tick_div #(
    parameter DIV = 10000
) (
    input wire mclk_in,
    input wire rstn_in,
    output reg tick_out
);
    reg [15:0] cnt_reg;
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg <= 16'h0000;
            tick_out <= 1'b0;
        end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
            cnt_reg <= 16'h0000;
            tick_out <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== hw/stdi_indicators.v
// Diagnostic and status indicator logic of the safety terminal.
// Assumes fault and state inputs from asynchronous sources; all are synchronised here.
`include "stdi_defines.vh"
`default_nettype none
// What this block does
// - Diag one lit while project stored
// - Diag three on; first flashes, second off
// - Controller fault latches global fault shutdown
// - Function block error: single uniform pulses
// - Communication error: groups of two pulses
// - Both errors: groups of three pulses
// - Supply or temperature fault: diag four steady
// - Temperature fault codes five, six, seven
// - Supply codes 0101 to 0104 per controller
// - No project: only status four lit
// - Preoperational: status three and four lit
// - Operational: all status indicators lit
// - Configuration write forces permanent fail-stop
// - Checksum two bytes v1, three v2
// - Versions 1 and 2, matching checksum length
// - Sequence check only under version 1
module stdi_indicators #(
    parameter TICK_CYCLES = `STDI_TICK_CYCLES,
    parameter PULSE_TICKS = `STDI_PULSE_TICKS,
    parameter GAP_TICKS = `STDI_GAP_TICKS,
    parameter PAUSE_TICKS = `STDI_PAUSE_TICKS
) (
    input wire mclk_in,
    input wire rstn_in,
    input wire project_stored_in,
    input wire first_controller_fault_in,
    input wire second_controller_fault_in,
    input wire fb_error_in,
    input wire comm_error_in,
    input wire temp_high_in,
    input wire temp_low_in,
    input wire temp_diff_in,
    input wire ov_first_in,
    input wire ov_second_in,
    input wire uv_first_in,
    input wire uv_second_in,
    input wire preoperational_state_in,
    input wire operational_state_in,
    input wire config_write_in,
    input wire [1:0] proto_version_in,
    input wire [1:0] crc_length_in,
    input wire seq_in_checksum_sel_in,
    output reg [3:0] diag_led_out,
    output reg [3:0] state_led_out,
    output reg [15:0] diag_fault_code_out,
    output reg global_fault_out,
    output reg fail_stop_out,
    output reg param_error_out,
    output reg [1:0] crc_bytes_out,
    output reg seq_covered_out
);
    ////////////////////////////////////////////////////////////////////
    // Input synchronisers, one generate lane per single-bit input pin
    localparam NSYNC = 16;
    wire [NSYNC-1:0] raw_in;
    reg [NSYNC-1:0] sync1_reg;
    reg [NSYNC-1:0] sync2_reg;
    assign raw_in = {seq_in_checksum_sel_in, config_write_in, operational_state_in,
        preoperational_state_in, uv_second_in, uv_first_in, ov_second_in, ov_first_in,
        temp_diff_in, temp_low_in, temp_high_in, comm_error_in, fb_error_in,
        second_controller_fault_in, first_controller_fault_in, project_stored_in};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= raw_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate
    // Static settings; a live change may show one skewed cycle
    reg [1:0] ver1_reg;
    reg [1:0] ver2_reg;
    reg [1:0] crc1_reg;
    reg [1:0] crc2_reg;
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ver1_reg <= 2'h0;
            ver2_reg <= 2'h0;
            crc1_reg <= 2'h0;
            crc2_reg <= 2'h0;
        end else begin
            ver1_reg <= proto_version_in;
            ver2_reg <= ver1_reg;
            crc1_reg <= crc_length_in;
            crc2_reg <= crc1_reg;
        end
    end
    wire project_s = sync2_reg[0];
    wire c1_fault_s = sync2_reg[1];
    wire c2_fault_s = sync2_reg[2];
    wire fb_err_s = sync2_reg[3];
    wire comm_err_s = sync2_reg[4];
    wire t_high_s = sync2_reg[5];
    wire t_low_s = sync2_reg[6];
    wire t_diff_s = sync2_reg[7];
    wire ov1_s = sync2_reg[8];
    wire ov2_s = sync2_reg[9];
    wire uv1_s = sync2_reg[10];
    wire uv2_s = sync2_reg[11];
    wire preop_s = sync2_reg[12];
    wire op_s = sync2_reg[13];
    wire cfg_wr_s = sync2_reg[14];
    wire seq_sel_s = sync2_reg[15];

    ////////////////////////////////////////////////////////////////////
    // Latched fault state
    reg c1_latched_reg;
    reg c2_latched_reg;
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            c1_latched_reg <= 1'b0;
            c2_latched_reg <= 1'b0;
            global_fault_out <= 1'b0;
        end else begin
            // First fault seen decides which controller is reported
            if (c1_fault_s && !global_fault_out)
                c1_latched_reg <= 1'b1;
            if (c2_fault_s && !c1_fault_s && !global_fault_out)
                c2_latched_reg <= 1'b1;
            if (c1_fault_s || c2_fault_s)
                global_fault_out <= 1'b1;
        end
    end
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in)
            fail_stop_out <= 1'b0;
        else if (cfg_wr_s)
            fail_stop_out <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Protocol parameter checks
    reg [1:0] crc_bytes_next;
    reg param_error_next;
    always @* begin
        crc_bytes_next = `STDI_CRC_LEN_V1;
        param_error_next = 1'b0;
        if (ver2_reg == `STDI_PROTO_V2)
            crc_bytes_next = `STDI_CRC_LEN_V2;
        if (ver2_reg != `STDI_PROTO_V1 && ver2_reg != `STDI_PROTO_V2)
            param_error_next = 1'b1;
        else if (crc2_reg != crc_bytes_next)
            param_error_next = 1'b1;
    end
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            crc_bytes_out <= `STDI_CRC_LEN_V1;
            param_error_out <= 1'b0;
            seq_covered_out <= 1'b0;
        end else begin
            crc_bytes_out <= crc_bytes_next;
            param_error_out <= param_error_next;
            seq_covered_out <= seq_sel_s && (ver2_reg == `STDI_PROTO_V1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Diagnostic code, priority temperature then supply
    reg [15:0] code_next;
    always @* begin
        code_next = `STDI_CODE_NONE;
        if (t_high_s)
            code_next = `STDI_CODE_TEMP_HIGH;
        else if (t_low_s)
            code_next = `STDI_CODE_TEMP_LOW;
        else if (t_diff_s)
            code_next = `STDI_CODE_TEMP_DIFF;
        else if (ov1_s)
            code_next = `STDI_CODE_OV_FIRST;
        else if (ov2_s)
            code_next = `STDI_CODE_OV_SECOND;
        else if (uv1_s)
            code_next = `STDI_CODE_UV_FIRST;
        else if (uv2_s)
            code_next = `STDI_CODE_UV_SECOND;
    end
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in)
            diag_fault_code_out <= `STDI_CODE_NONE;
        else
            diag_fault_code_out <= code_next;
    end
    wire env_fault = (code_next != `STDI_CODE_NONE);

    ////////////////////////////////////////////////////////////////////
    // Blink pattern generator
    wire tick;
    stdi_tick_div #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .tick_out(tick)
    );
    localparam ST_IDLE = 2'h0;
    localparam ST_ON = 2'h1;
    localparam ST_GAP = 2'h2;
    localparam ST_PAUSE = 2'h3;
    reg [1:0] st_reg;
    reg [1:0] st_next;
    reg [15:0] tcnt_reg;
    reg [15:0] tcnt_next;
    reg [1:0] pcnt_reg;
    reg [1:0] pcnt_next;
    reg [1:0] want_pulses;
    always @* begin
        want_pulses = 2'h0;
        if (fb_err_s && comm_err_s)
            want_pulses = 2'h3;
        else if (comm_err_s)
            want_pulses = 2'h2;
        else if (fb_err_s)
            want_pulses = 2'h1;
    end
    // Single pulses use the short gap so the flashing looks uniform
    always @* begin
        st_next = st_reg;
        tcnt_next = tcnt_reg;
        pcnt_next = pcnt_reg;
        case (st_reg)
            ST_IDLE: begin
                if (want_pulses != 2'h0 && tick) begin
                    st_next = ST_ON;
                    tcnt_next = 16'h0000;
                    pcnt_next = 2'h1;
                end
            end
            ST_ON: begin
                if (tick) begin
                    if (tcnt_reg == PULSE_TICKS[15:0] - 16'h0001) begin
                        tcnt_next = 16'h0000;
                        if (want_pulses == 2'h1 || pcnt_reg < want_pulses)
                            st_next = ST_GAP;
                        else
                            st_next = ST_PAUSE;
                    end else begin
                        tcnt_next = tcnt_reg + 16'h0001;
                    end
                end
            end
            ST_GAP: begin
                if (tick) begin
                    if (tcnt_reg == GAP_TICKS[15:0] - 16'h0001) begin
                        tcnt_next = 16'h0000;
                        if (want_pulses == 2'h0) begin
                            st_next = ST_IDLE;
                        end else begin
                            st_next = ST_ON;
                            pcnt_next = (want_pulses == 2'h1) ? 2'h1 : pcnt_reg + 2'h1;
                        end
                    end else begin
                        tcnt_next = tcnt_reg + 16'h0001;
                    end
                end
            end
            ST_PAUSE: begin
                if (tick) begin
                    if (tcnt_reg == PAUSE_TICKS[15:0] - 16'h0001) begin
                        tcnt_next = 16'h0000;
                        st_next = ST_IDLE;
                    end else begin
                        tcnt_next = tcnt_reg + 16'h0001;
                    end
                end
            end
            default: begin
                st_next = ST_IDLE;
                tcnt_next = 16'h0000;
                pcnt_next = 2'h0;
            end
        endcase
    end
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= ST_IDLE;
            tcnt_reg <= 16'h0000;
            pcnt_reg <= 2'h0;
        end else begin
            st_reg <= st_next;
            tcnt_reg <= tcnt_next;
            pcnt_reg <= pcnt_next;
        end
    end
    // Free-running half-period toggle for the controller fault flash
    reg flash_reg;
    reg [15:0] fcnt_reg;
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flash_reg <= 1'b0;
            fcnt_reg <= 16'h0000;
        end else if (tick) begin
            if (fcnt_reg == PULSE_TICKS[15:0] - 16'h0001) begin
                fcnt_reg <= 16'h0000;
                flash_reg <= ~flash_reg;
            end else begin
                fcnt_reg <= fcnt_reg + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // LED outputs
    reg [3:0] diag_next;
    reg [3:0] state_next;
    always @* begin
        diag_next = 4'h0;
        diag_next[0] = project_s;
        if (global_fault_out) begin
            diag_next[2] = 1'b1;
            diag_next[3] = c1_latched_reg ? flash_reg : 1'b0;
        end else if (env_fault) begin
            // steady on for supply or temperature
            diag_next[3] = 1'b1;
        end else begin
            diag_next[3] = (st_reg == ST_ON);
        end
        state_next = 4'h8;
        if (project_s) begin
            if (op_s)
                state_next = 4'hf;
            else if (preop_s)
                state_next = 4'hc;
        end
    end
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            diag_led_out <= 4'h0;
            state_led_out <= 4'h8;
        end else begin
            diag_led_out <= diag_next;
            state_led_out <= state_next;
        end
    end
endmodule
`default_nettype wire

// ===== verif/stdi_monitor.sv
// Checker for the diagnostic indicator block, bound to its top ports.
// Assumes inputs held five cycles to pass the input synchronisers.
`default_nettype none
module stdi_monitor (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic project_stored_in,
    input wire logic first_controller_fault_in,
    input wire logic second_controller_fault_in,
    input wire logic operational_state_in,
    input wire logic temp_high_in,
    input wire logic config_write_in,
    input wire logic [1:0] proto_version_in,
    input wire logic [3:0] diag_led_out,
    input wire logic [3:0] state_led_out,
    input wire logic [15:0] diag_fault_code_out,
    input wire logic global_fault_out,
    input wire logic fail_stop_out,
    input wire logic [1:0] crc_bytes_out,
    input wire logic seq_covered_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////
    // Global fault may override the leds, so those checks exclude it
    property p_diag1; project_stored_in [*5] ##0 !global_fault_out |-> diag_led_out[0]; endproperty
    a_diag1: assert property (p_diag1) else $error("diag one dark with project");
    property p_fault_raise; $rose(first_controller_fault_in || second_controller_fault_in) |-> ##[1:4] global_fault_out;
    endproperty
    a_fault_raise: assert property (p_fault_raise) else $error("no global fault");
    property p_fault_hold; global_fault_out |=> global_fault_out && diag_led_out[2]; endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("global fault lost");
    property p_stop; config_write_in |-> ##[1:4] fail_stop_out; endproperty
    a_stop: assert property (p_stop) else $error("no fail stop");
    property p_stop_hold; fail_stop_out |=> $stable(fail_stop_out); endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("fail stop left");
    property p_env; temp_high_in [*5] ##0 !global_fault_out |-> diag_led_out[3] && diag_fault_code_out == 16'h0005;
    endproperty
    a_env: assert property (p_env) else $error("temperature fault not shown");
    property p_no_proj; !project_stored_in [*5] ##0 !global_fault_out |-> state_led_out == 4'h8; endproperty
    a_no_proj: assert property (p_no_proj) else $error("bad state leds");
    property p_op; (project_stored_in && operational_state_in) [*5] ##0 !global_fault_out |-> state_led_out == 4'hf;
    endproperty
    a_op: assert property (p_op) else $error("bad operational leds");
    property p_crc; (proto_version_in == 2'h2) [*5] |-> crc_bytes_out == 2'h3; endproperty
    a_crc: assert property (p_crc) else $error("bad checksum length");
    property p_seq; (proto_version_in != 2'h1) [*5] |-> !seq_covered_out; endproperty
    a_seq: assert property (p_seq) else $error("sequence covered outside v1");
    c_fault: cover property (global_fault_out && !diag_led_out[3]);
    c_stop: cover property ($rose(fail_stop_out));
    c_blink: cover property ($rose(diag_led_out[3]) ##4 !diag_led_out[3]);
endmodule
bind stdi_indicators stdi_monitor mon_u (.*);
`default_nettype wire

// ===== verif/stdi_host_model.sv
// Host model: supplies the safety connection parameters.
// Assumes the bench picks version, a deliberate mismatch and the sequence choice.
`default_nettype none
module stdi_host_model (
    input wire logic [1:0] ver_in,
    input wire logic bad_in,
    input wire logic seq_in,
    output logic [1:0] proto_version_out,
    output logic [1:0] crc_length_out,
    output logic seq_sel_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BUS_CYCLE_US = 1000;
    localparam int WATCHDOG_US = 4 * BUS_CYCLE_US;
    localparam int DEST_ADDR = 1;
    localparam int SRC_ADDR = 2;
    assign crc_length_out = ((ver_in == 2'h2) ^ bad_in) ? 2'h3 : 2'h2;
    assign seq_sel_out = seq_in;
    assign proto_version_out = ver_in;
endmodule
`default_nettype wire

// ===== verif/stdi_indicators_test.sv
// Self-checking bench for the diagnostic indicator block.
// Assumes shortened blink timing: tick 2 cycles, pulse and gap 2 ticks, pause 5.
`default_nettype none
module stdi_indicators_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [13:0] in; logic [15:0] code; logic [1:0] crc; logic sc, pe;} stdi_row_t;
    logic mclk_in, rstn_in, project_stored_in, first_controller_fault_in, second_controller_fault_in;
    logic fb_error_in, comm_error_in, preoperational_state_in, operational_state_in, config_write_in, bad, seq;
    logic [6:0] env;
    logic [1:0] ver;
    wire logic temp_high_in, temp_low_in, temp_diff_in, ov_first_in, ov_second_in, uv_first_in, uv_second_in;
    wire logic [1:0] proto_version_in, crc_length_in, crc_bytes_out;
    wire logic seq_in_checksum_sel_in, global_fault_out, fail_stop_out, param_error_out, seq_covered_out;
    wire logic [3:0] diag_led_out, state_led_out;
    wire logic [15:0] diag_fault_code_out;
    int num_errors = 0;
    int num_checks = 0;
    int grp, rises, maxlow, ok;
    int bk[4] = '{1, 2, 3, 5};
    // Inputs: project, preop, op; env faults; version; mismatch, sequence
    stdi_row_t rows[17] = '{
        '{{3'b000, 7'h00, 2'h1, 2'b00}, 16'h0000, 2'h2, 1'b0, 1'b0}, '{{3'b110, 7'h00, 2'h1, 2'b00}, 16'h0000, 2'h2, 1'b0, 1'b0},
        '{{3'b101, 7'h00, 2'h1, 2'b01}, 16'h0000, 2'h2, 1'b1, 1'b0}, '{{3'b110, 7'h40, 2'h1, 2'b00}, 16'h0005, 2'h2, 1'b0, 1'b0},
        '{{3'b110, 7'h20, 2'h1, 2'b00}, 16'h0006, 2'h2, 1'b0, 1'b0}, '{{3'b110, 7'h10, 2'h1, 2'b00}, 16'h0007, 2'h2, 1'b0, 1'b0},
        '{{3'b110, 7'h08, 2'h1, 2'b00}, 16'h0101, 2'h2, 1'b0, 1'b0}, '{{3'b110, 7'h04, 2'h1, 2'b00}, 16'h0102, 2'h2, 1'b0, 1'b0},
        '{{3'b110, 7'h02, 2'h1, 2'b00}, 16'h0103, 2'h2, 1'b0, 1'b0}, '{{3'b110, 7'h01, 2'h1, 2'b00}, 16'h0104, 2'h2, 1'b0, 1'b0},
        '{{3'b110, 7'h41, 2'h1, 2'b00}, 16'h0005, 2'h2, 1'b0, 1'b0}, '{{3'b101, 7'h00, 2'h2, 2'b01}, 16'h0000, 2'h3, 1'b0, 1'b0},
        '{{3'b101, 7'h00, 2'h2, 2'b10}, 16'h0000, 2'h3, 1'b0, 1'b1}, '{{3'b101, 7'h00, 2'h3, 2'b00}, 16'h0000, 2'h2, 1'b0, 1'b1},
        '{{3'b101, 7'h00, 2'h1, 2'b10}, 16'h0000, 2'h2, 1'b0, 1'b1},
        '{{3'b100, 7'h00, 2'h1, 2'b00}, 16'h0000, 2'h2, 1'b0, 1'b0}, '{{3'b111, 7'h00, 2'h1, 2'b00}, 16'h0000, 2'h2, 1'b0, 1'b0}};
    assign {temp_high_in, temp_low_in, temp_diff_in, ov_first_in, ov_second_in, uv_first_in, uv_second_in} = env;
    stdi_indicators #(.TICK_CYCLES(2), .PULSE_TICKS(2), .GAP_TICKS(2), .PAUSE_TICKS(5)) dut_u (.*);
    stdi_host_model host_u (.ver_in(ver), .bad_in(bad), .seq_in(seq), .proto_version_out(proto_version_in),
        .crc_length_out(crc_length_in), .seq_sel_out(seq_in_checksum_sel_in));
    ////////////////////////////////////////////////////////////////
    task step;
        @(posedge mclk_in);
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // A low run above seven cycles is a pause; the last whole group is kept
    task measure;
        int run, cnt;
        logic prev;
        grp = 0; rises = 0; maxlow = 0; run = 0; cnt = 0; prev = diag_led_out[3];
        repeat (400) begin
            step;
            if (diag_led_out[3] === 1'b1) begin
                if (prev !== 1'b1) begin
                    if (run > 7) begin
                        grp = cnt;
                        cnt = 0;
                    end
                    cnt++;
                    rises++;
                end
                run = 0;
            end else begin
                run++;
                if (run > maxlow) maxlow = run;
            end
            prev = diag_led_out[3];
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk_in = 0;
        forever #50 mclk_in = ~mclk_in;
    end
    // Whole run is near 3000 cycles, so 20000 means a hang
    initial begin
        #2000000;
        num_errors++;
        $display("BAD %0t watchdog", $time);
        test_done;
    end
    initial begin
        {rstn_in, project_stored_in, first_controller_fault_in, second_controller_fault_in, fb_error_in} = 0;
        {comm_error_in, preoperational_state_in, operational_state_in, config_write_in, bad, seq, env} = 0;
        ver = 2'h1;
        repeat (4) @(posedge mclk_in);
        #1;
        chk(state_led_out, 4'h8, "reset state");
        chk(diag_fault_code_out, 16'h0000, "reset code");
        chk({diag_led_out, global_fault_out, fail_stop_out, crc_bytes_out}, 8'h02, "reset flags");
        chk(host_u.WATCHDOG_US > host_u.BUS_CYCLE_US, 1'b1, "watchdog time");
        chk(host_u.DEST_ADDR != host_u.SRC_ADDR, 1'b1, "addresses");
        $display("reset done");
        rstn_in = 1;
        foreach (rows[i]) begin
            {project_stored_in, preoperational_state_in, operational_state_in, env, ver, bad, seq} = rows[i].in;
            repeat (6) step;
            chk(state_led_out, !project_stored_in ? 4'h8 : operational_state_in ? 4'hf :
                preoperational_state_in ? 4'hc : 4'h8, "state");
            chk(diag_led_out, {env != 0, 2'b00, project_stored_in}, "diag");
            chk(diag_fault_code_out, rows[i].code, "code");
            chk(crc_bytes_out, rows[i].crc, "crc");
            chk(seq_covered_out, rows[i].sc, "seq");
            chk(param_error_out, rows[i].pe, "param");
        end
        $display("table done");
        foreach (bk[j]) begin
            {env[6], comm_error_in, fb_error_in} = bk[j][2:0];
            repeat (40) step;
            measure;
            ok = (bk[j] == 1) ? (maxlow < 8 && rises > 20) : (bk[j] == 5) ? (rises == 0 && diag_led_out[3] === 1'b1)
                : (grp == bk[j]);
            chk(ok, 1, "blink");
        end
        $display("blink done");
        {env, comm_error_in, fb_error_in} = 0;
        config_write_in = 1;
        step;
        config_write_in = 0;
        repeat (5) step;
        chk(fail_stop_out, 1'b1, "fail stop");
        second_controller_fault_in = 1;
        repeat (6) step;
        chk(global_fault_out, 1'b1, "global fault");
        measure;
        chk({diag_led_out[2], rises == 0 && diag_led_out[3] === 1'b0}, 2'b11, "second dark");
        second_controller_fault_in = 0;
        rstn_in = 0;
        repeat (2) step;
        chk({global_fault_out, fail_stop_out}, 2'b00, "mid reset");
        rstn_in = 1;
        first_controller_fault_in = 1;
        repeat (6) step;
        measure;
        chk({diag_led_out[2], rises > 2}, 2'b11, "first flashes");
        $display("fault done");
        test_done;
    end
endmodule
`default_nettype wire
